// ==== rtl/lofc_pkg.sv ====
// Operation
// - Link bit clear with stream mode 00 or 01 drives both channels as one dual link.
// - Link bit clear with stream mode 10 runs the channels as two independent single links.
// - Link bit set, its reset value, runs single link with channel A on and channel B off.
// - Format bit 3 gives channel A 18bpp with lane four off at 0, 24bpp with lane four on at 1.
// - Format bit 2 gives channel B 18bpp with lane four off at 0, 24bpp with lane four on at 1 while the link bit is clear.
// - Format bit 1 puts channel A colour MSBs on lane four at 0 and LSBs there at 1.
// - Format bit 0 puts channel B colour MSBs on lane four at 0 and LSBs there at 1.
// - Layout bit one with 18bpp depth reduces 24bpp input by dropping two LSBs per colour.
// - Level bit 6 picks channel A common level 1.2V or 0.9V; 0.9V needs channel A trim 01.
// - Level bit 4 picks channel B common level 1.2V or 0.9V; 0.9V needs channel B trim 01.
// - Swing fields at bits 3:2 for A and 1:0 for B take four settings and reset to 01.
// - Each trim field applies 00 none, 01 down 3 percent, 10 up 3 percent, 11 up 6 percent.
package lofc_pkg;
	// Register indices and their word addresses on the bus.
	localparam logic [7:0]  STREAM_IDX = 8'h10;
	localparam logic [7:0]  FORMAT_IDX = 8'h18;
	localparam logic [7:0]  LEVEL_IDX  = 8'h19;
	localparam logic [7:0]  TRIM_IDX   = 8'h1b;
	localparam logic [7:0]  STATUS_IDX = 8'h1c;
	localparam logic [9:0]  STREAM_ADR = {STREAM_IDX, 2'b00};
	localparam logic [9:0]  FORMAT_ADR = {FORMAT_IDX, 2'b00};
	localparam logic [9:0]  LEVEL_ADR  = {LEVEL_IDX, 2'b00};
	localparam logic [9:0]  TRIM_ADR   = {TRIM_IDX, 2'b00};
	localparam logic [9:0]  STATUS_ADR = {STATUS_IDX, 2'b00};
	// Field positions.
	localparam int STREAM_LSB   = 5;
	localparam int LINK_BIT     = 4;
	localparam int A_DEPTH_BIT  = 3;
	localparam int B_DEPTH_BIT  = 2;
	localparam int A_LAYOUT_BIT = 1;
	localparam int B_LAYOUT_BIT = 0;
	localparam int A_LEVEL_BIT  = 6;
	localparam int B_LEVEL_BIT  = 4;
	localparam int A_SWING_LSB  = 2;
	localparam int B_SWING_LSB  = 0;
	localparam int A_TRIM_LSB   = 4;
	localparam int B_TRIM_LSB   = 0;
	// Reset values.
	localparam logic [1:0] STREAM_RST = 2'h0;
	localparam logic [4:0] FORMAT_RST = 5'h10;
	localparam logic [1:0] LEVEL_RST  = 2'h0;
	localparam logic [3:0] SWING_RST  = 4'h5;
	localparam logic [3:0] TRIM_RST   = 4'h0;
	// Stream mode that splits the input into two streams.
	localparam logic [1:0] STREAM_TWO = 2'h2;
	// Trim code paired with the low common level.
	localparam logic [1:0] TRIM_LOW   = 2'h1;
	// Output link arrangement, Gray coded.
	typedef enum logic [1:0] {
		LINK_SINGLE = 2'b00,
		LINK_DUAL   = 2'b01,
		LINK_SPLIT  = 2'b11
	} lofc_link_type;
endpackage

// ==== rtl/lofc_top.sv ====
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module lofc_top (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pixels for each channel, R in 23:16, G in 15:8, B in 7:0.
	input  wire logic [23:0] first_pixel,
	input  wire logic [23:0] second_pixel,
	// Colour bits for the three base lanes and for lane four.
	output logic      [17:0] first_channel_base_bits,
	output logic      [5:0]  first_channel_fourth_bits,
	output logic      [17:0] second_channel_base_bits,
	output logic      [5:0]  second_channel_fourth_bits,
	// Link arrangement.
	output logic             dual_link_enable,
	output logic             split_link_enable,
	output logic             first_channel_enable,
	output logic             second_channel_enable,
	output logic             first_channel_fourth_lane,
	output logic             second_channel_fourth_lane,
	// Analog settings.
	output logic             first_channel_common_level,
	output logic             second_channel_common_level,
	output logic      [1:0]  first_channel_swing,
	output logic      [1:0]  second_channel_swing,
	output logic signed [3:0] first_channel_trim_pct,
	output logic signed [3:0] second_channel_trim_pct
);

	// Splits one pixel into base lane bits and lane four bits.
	function automatic logic [23:0] lane_map(input logic [23:0] px, input logic deep,
			input logic lsb_on_four);
		logic [17:0] base;
		logic [5:0]  four;
		base = {px[23:18], px[15:10], px[7:2]};
		four = 6'h00;
		if (deep && !lsb_on_four) begin
			base = {px[21:16], px[13:8], px[5:0]};
			four = {px[23:22], px[15:14], px[7:6]};
		end else if (deep) begin
			four = {px[17:16], px[9:8], px[1:0]};
		end
		return {base, four};
	endfunction

	// Turns a trim code into a signed percentage.
	function automatic logic signed [3:0] trim_pct(input logic [1:0] code);
		case (code)
			2'h1:    trim_pct = -4'sd3;
			2'h2:    trim_pct = 4'sd3;
			2'h3:    trim_pct = 4'sd6;
			default: trim_pct = 4'sd0;
		endcase
	endfunction

	// Register state.
	logic [1:0]  stream_reg, stream_next;
	logic [4:0]  format_reg, format_next;
	logic [1:0]  level_reg, level_next;
	logic [3:0]  swing_reg, swing_next;
	logic [3:0]  trim_reg, trim_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	lofc_pkg::lofc_link_type link_reg, link_next;
	logic        mismatch_reg, mismatch_next;
	logic        hit;
	logic        commit;
	logic [31:0] rd_word;

	// Address decode and read mux.
	always_comb begin
		hit = 1'b1;
		rd_word = 32'h0000_0000;
		case (paddr)
			lofc_pkg::STREAM_ADR: rd_word[6:5] = stream_reg;
			lofc_pkg::FORMAT_ADR: rd_word[4:0] = format_reg;
			lofc_pkg::LEVEL_ADR:  rd_word[6:0] = {level_reg[1], 1'b0, level_reg[0], swing_reg};
			lofc_pkg::TRIM_ADR:   rd_word[5:0] = {trim_reg[3:2], 2'b00, trim_reg[1:0]};
			lofc_pkg::STATUS_ADR: rd_word[3:0] = {link_reg, 1'b0, mismatch_reg}; // Bit 1 unused.
			default:              hit = 1'b0;
		endcase
	end

	// One wait state: answer in the second access cycle, commit at the edge that takes it.
	always_comb begin
		commit = psel && penable && pready_reg;
		pready_next = psel && penable && !pready_reg;
		pslverr_next = pready_next && !hit;
		prdata_next = prdata_reg;
		if (pready_next && !pwrite) begin
			prdata_next = hit ? rd_word : 32'h0000_0000;
		end
	end

	// Register writes take effect only on a committed, mapped write.
	always_comb begin
		stream_next = stream_reg;
		format_next = format_reg;
		level_next = level_reg;
		swing_next = swing_reg;
		trim_next = trim_reg;
		if (commit && pwrite && !pslverr_reg) begin
			case (paddr)
				lofc_pkg::STREAM_ADR: stream_next = pwdata[6:5];
				lofc_pkg::FORMAT_ADR: format_next = pwdata[4:0];
				lofc_pkg::LEVEL_ADR: begin
					level_next = {pwdata[lofc_pkg::A_LEVEL_BIT], pwdata[lofc_pkg::B_LEVEL_BIT]};
					swing_next = pwdata[3:0];
				end
				lofc_pkg::TRIM_ADR:   trim_next = {pwdata[5:4], pwdata[1:0]};
				default:              stream_next = stream_reg;
			endcase
		end
	end

	// Bus and register flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stream_reg <= lofc_pkg::STREAM_RST;
			format_reg <= lofc_pkg::FORMAT_RST;
			level_reg <= lofc_pkg::LEVEL_RST;
			swing_reg <= lofc_pkg::SWING_RST;
			trim_reg <= lofc_pkg::TRIM_RST;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			stream_reg <= stream_next;
			format_reg <= format_next;
			level_reg <= level_next;
			swing_reg <= swing_next;
			trim_reg <= trim_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// Derived output state.
	logic [23:0] a_map, b_map;
	logic [17:0] a_base_reg, a_base_next, b_base_reg, b_base_next;
	logic [5:0]  a_four_reg, a_four_next, b_four_reg, b_four_next;
	logic        a_deep, b_deep;

	// Picks the link arrangement and maps pixels onto lanes.
	always_comb begin
		a_deep = format_reg[lofc_pkg::A_DEPTH_BIT];
		b_deep = format_reg[lofc_pkg::B_DEPTH_BIT];
		if (format_reg[lofc_pkg::LINK_BIT]) begin
			link_next = lofc_pkg::LINK_SINGLE;
		end else if (stream_reg == lofc_pkg::STREAM_TWO) begin
			link_next = lofc_pkg::LINK_SPLIT;
		end else begin
			link_next = lofc_pkg::LINK_DUAL;
		end
		// Lane four content depends on layout; 18bpp drops two LSBs per colour.
		a_map = lane_map(first_pixel, a_deep, format_reg[lofc_pkg::A_LAYOUT_BIT]);
		b_map = lane_map(second_pixel, b_deep, format_reg[lofc_pkg::B_LAYOUT_BIT]);
		a_base_next = a_map[23:6];
		a_four_next = a_map[5:0];
		b_base_next = 18'h00000;
		b_four_next = 6'h00;
		if (link_next != lofc_pkg::LINK_SINGLE) begin
			b_base_next = b_map[23:6];
			b_four_next = b_map[5:0];
		end
		// Flags a low common level whose trim is not the paired code.
		mismatch_next = (level_reg[1] && trim_reg[3:2] != lofc_pkg::TRIM_LOW)
			|| (level_reg[0] && trim_reg[1:0] != lofc_pkg::TRIM_LOW);
	end

	// Output flip-flops for link and data.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_reg <= lofc_pkg::LINK_SINGLE;
			mismatch_reg <= 1'b0;
			a_base_reg <= 18'h00000;
			a_four_reg <= 6'h00;
			b_base_reg <= 18'h00000;
			b_four_reg <= 6'h00;
		end else begin
			link_reg <= link_next;
			mismatch_reg <= mismatch_next;
			a_base_reg <= a_base_next;
			a_four_reg <= a_four_next;
			b_base_reg <= b_base_next;
			b_four_reg <= b_four_next;
		end
	end

	// Analog and enable outputs, registered.
	logic        a_lane4_reg, b_lane4_reg;
	logic [1:0]  lvl_out_reg;
	logic [3:0]  swing_out_reg;
	logic signed [3:0] a_pct_reg, b_pct_reg;
	logic        a_en_reg, b_en_reg, dual_reg, split_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_lane4_reg <= 1'b0;
			b_lane4_reg <= 1'b0;
			lvl_out_reg <= lofc_pkg::LEVEL_RST;
			swing_out_reg <= lofc_pkg::SWING_RST;
			a_pct_reg <= 4'sd0;
			b_pct_reg <= 4'sd0;
			a_en_reg <= 1'b0;
			b_en_reg <= 1'b0;
			dual_reg <= 1'b0;
			split_reg <= 1'b0;
		end else begin
			a_lane4_reg <= a_deep;
			b_lane4_reg <= b_deep && link_next != lofc_pkg::LINK_SINGLE;
			lvl_out_reg <= level_reg;
			swing_out_reg <= swing_reg;
			a_pct_reg <= trim_pct(trim_reg[3:2]);
			b_pct_reg <= trim_pct(trim_reg[1:0]);
			// Enables come from flops so the pins never glitch on a decode.
			a_en_reg <= 1'b1;
			b_en_reg <= (link_next != lofc_pkg::LINK_SINGLE);
			dual_reg <= (link_next == lofc_pkg::LINK_DUAL);
			split_reg <= (link_next == lofc_pkg::LINK_SPLIT);
		end
	end

	// Port drive.
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign first_channel_base_bits = a_base_reg;
	assign first_channel_fourth_bits = a_four_reg;
	assign second_channel_base_bits = b_base_reg;
	assign second_channel_fourth_bits = b_four_reg;
	assign dual_link_enable = dual_reg;
	assign split_link_enable = split_reg;
	assign first_channel_enable = a_en_reg;
	assign second_channel_enable = b_en_reg;
	assign first_channel_fourth_lane = a_lane4_reg;
	assign second_channel_fourth_lane = b_lane4_reg;
	assign first_channel_common_level = lvl_out_reg[1];
	assign second_channel_common_level = lvl_out_reg[0];
	assign first_channel_swing = swing_out_reg[3:2];
	assign second_channel_swing = swing_out_reg[1:0];
	assign first_channel_trim_pct = a_pct_reg;
	assign second_channel_trim_pct = b_pct_reg;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Bus handshake steps.
	sequence access_s;
		psel && penable && !pready;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence

	apb_wait_state_a: assert property (access_s |=> answer_s)
		else $error("pready did not pulse one cycle after access");
	format_hold_a: assert property (commit && pwrite && paddr == lofc_pkg::FORMAT_ADR && hit
			|=> format_reg == $past(pwdata[4:0]))
		else $error("format write not stored");
	single_link_a: assert property (format_reg[lofc_pkg::LINK_BIT] |=> !second_channel_enable
			&& !dual_link_enable)
		else $error("channel B active in single link");
	dual_link_a: assert property (!format_reg[lofc_pkg::LINK_BIT]
			&& stream_reg != lofc_pkg::STREAM_TWO |=> dual_link_enable)
		else $error("dual link not selected");
	split_link_a: assert property (!format_reg[lofc_pkg::LINK_BIT]
			&& stream_reg == lofc_pkg::STREAM_TWO |=> split_link_enable)
		else $error("two single links not selected");
	lane_four_a: assert property (!format_reg[lofc_pkg::A_DEPTH_BIT] |=> !first_channel_fourth_lane
			&& first_channel_fourth_bits == 6'h00)
		else $error("channel A lane four active at 18bpp");
	b_lane_four_a: assert property (!format_reg[lofc_pkg::B_DEPTH_BIT] |=> second_channel_fourth_bits
			== 6'h00 && !second_channel_fourth_lane)
		else $error("channel B lane four active at 18bpp");
	msb_layout_a: assert property (format_reg[4:0] == 5'h08
			|=> first_channel_fourth_bits == {$past(first_pixel[23:22]),
			$past(first_pixel[15:14]), $past(first_pixel[7:6])})
		else $error("channel A MSB layout wrong");
	a_lsb_layout_a: assert property (format_reg[4:0] == 5'h0a
			|=> first_channel_fourth_bits == {$past(first_pixel[17:16]),
			$past(first_pixel[9:8]), $past(first_pixel[1:0])})
		else $error("channel A LSB layout wrong");
	b_msb_layout_a: assert property (format_reg[4:0] == 5'h04
			|=> second_channel_fourth_bits == {$past(second_pixel[23:22]),
			$past(second_pixel[15:14]), $past(second_pixel[7:6])})
		else $error("channel B MSB layout wrong");
	b_lsb_layout_a: assert property (format_reg[4:0] == 5'h05
			|=> second_channel_fourth_bits == {$past(second_pixel[17:16]),
			$past(second_pixel[9:8]), $past(second_pixel[1:0])})
		else $error("channel B LSB layout wrong");
	truncate_a: assert property (format_reg[4:0] == 5'h02
			|=> first_channel_base_bits == {$past(first_pixel[23:18]),
			$past(first_pixel[15:10]), $past(first_pixel[7:2])})
		else $error("channel A reduction wrong");
	trim_apply_a: assert property (trim_reg[3:2] == 2'h3 [*2]
			|-> first_channel_trim_pct == 4'sd6)
		else $error("channel A trim not applied");
	b_trim_apply_a: assert property (trim_reg[1:0] == 2'h1 [*2]
			|-> second_channel_trim_pct == -4'sd3)
		else $error("channel B trim not applied");
	swing_copy_a: assert property (presetn
			|=> {first_channel_swing, second_channel_swing} == $past(swing_reg))
		else $error("swing outputs do not follow the register");
	first_enable_a: assert property (presetn |=> first_channel_enable)
		else $error("channel A not enabled after reset");
endmodule

// ==== dv/lofc_panel.sv ====
`timescale 1ns/1ps
// Panel receiver: rebuilds each channel word from base lanes and lane four.
module lofc_panel (
	// Channel A lanes.
	input  wire logic [17:0] a_base,
	input  wire logic [5:0]  a_four,
	input  wire logic        a_four_on,
	// Channel B lanes.
	input  wire logic [17:0] b_base,
	input  wire logic [5:0]  b_four,
	input  wire logic        b_four_on,
	// Received words, base bits above lane four bits.
	output logic      [23:0] a_word,
	output logic      [23:0] b_word
);
	// A disabled lane four carries nothing, so it is read as zero.
	assign a_word = {a_base, a_four_on ? a_four : 6'h00};
	assign b_word = {b_base, b_four_on ? b_four : 6'h00};
endmodule

// ==== dv/lvds_output_format_config_test.sv ====
`timescale 1ns/1ps
module lvds_output_format_config_test;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        [9:0] paddr;
	logic       [31:0] pwdata, prdata, rd;
	logic       [23:0] px_a, px_b, a_word, b_word;
	logic       [17:0] a_base, b_base;
	logic        [5:0] a_four, b_four;
	logic              dual, split, a_en, b_en, a_on, b_on, a_lvl, b_lvl;
	logic        [1:0] a_sw, b_sw;
	logic signed [3:0] a_tr, b_tr;
	logic        [7:0] lv, tr;
	int                err_total, n_checks, seed, s, l, f, k;

	lofc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .first_pixel(px_a), .second_pixel(px_b),
		.first_channel_base_bits(a_base), .first_channel_fourth_bits(a_four),
		.second_channel_base_bits(b_base), .second_channel_fourth_bits(b_four),
		.dual_link_enable(dual), .split_link_enable(split), .first_channel_enable(a_en),
		.second_channel_enable(b_en), .first_channel_fourth_lane(a_on),
		.second_channel_fourth_lane(b_on), .first_channel_common_level(a_lvl),
		.second_channel_common_level(b_lvl), .first_channel_swing(a_sw),
		.second_channel_swing(b_sw), .first_channel_trim_pct(a_tr),
		.second_channel_trim_pct(b_tr));
	lofc_panel panel (.a_base, .a_four, .a_four_on(a_on), .b_base, .b_four,
		.b_four_on(b_on), .a_word, .b_word);

	// Clock at 200 MHz.
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits for pready under a bound.
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Expected lane word for one channel from depth and layout.
	function automatic logic [23:0] exp_word(input logic [23:0] p, input logic d, input logic y);
		if (!d) return {p[23:18], p[15:10], p[7:2], 6'h00};
		if (y) return {p[23:18], p[15:10], p[7:2], p[17:16], p[9:8], p[1:0]};
		return {p[21:16], p[13:8], p[5:0], p[23:22], p[15:14], p[7:6]};
	endfunction

	function automatic logic [3:0] pct(input logic [1:0] c);
		return c == 2'h0 ? 4'h0 : c == 2'h1 ? 4'hd : c == 2'h2 ? 4'h3 : 4'h6;
	endfunction

	// Main sequence: reset, registers, link modes, pixel formats, analog fields.
	initial begin
		seed = 96476;
		err_total = 0;
		n_checks = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, px_a, px_b} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		chk(32'({dual, split, a_en, b_en, a_sw, b_sw}), 32'h25);
		apb(1'b0, 10'h060, 32'h0);
		chk(rd, 32'h10);
		apb(1'b0, 10'h064, 32'h0);
		chk(rd, 32'h05);
		apb(1'b1, 10'h3fc, 32'hff);
		chk(32'(err), 32'h1);
		apb(1'b0, 10'h3fc, 32'h0);
		chk(rd, 32'h0);
		for (s = 0; s < 3; s++) begin
			for (l = 0; l < 2; l++) begin
				apb(1'b1, 10'h040, {25'h0, s[1:0], 5'h0});
				apb(1'b1, 10'h060, {27'h0, l[0], 4'h0});
				apb(1'b0, 10'h070, 32'h0);
				chk(32'({dual, split, b_en}), 32'({!l && s != 2, !l && s == 2, !l}));
				chk(32'(rd[3:2]), l ? 32'h0 : s == 2 ? 32'h3 : 32'h1);
			end
		end
		for (f = 0; f < 16; f++) begin
			apb(1'b1, 10'h060, {28'h0, f[3:0]});
			apb(1'b0, 10'h060, 32'h0);
			chk(rd, 32'(f));
			chk(32'({a_on, b_on}), 32'(f[3:2]));
			for (k = 0; k < 3; k++) begin
				@(posedge pclk);
				// Narrow source video only arrives while no layout bit is set.
				lv = (f[1:0] == 2'h0 && k == 0) ? 8'hfc : 8'hff;
				px_a <= 24'($random(seed)) & {3{lv}};
				px_b <= 24'($random(seed)) & {3{lv}};
				@(posedge pclk);
				#1;
				chk(32'(a_word), 32'(exp_word(px_a, f[3], f[1])));
				chk(32'(b_word), 32'(exp_word(px_b, f[2], f[0])));
			end
		end
		for (k = 0; k < 10; k++) begin
			lv = 8'($random(seed)) & 8'h5f;
			tr = 8'($random(seed)) & 8'h33;
			apb(1'b1, 10'h064, {24'h0, lv});
			apb(1'b1, 10'h06c, {24'h0, tr});
			apb(1'b0, 10'h064, 32'h0);
			chk(rd, 32'(lv));
			apb(1'b0, 10'h070, 32'h0);
			chk(32'(rd[0]), 32'((lv[6] && tr[5:4] != 2'h1) || (lv[4] && tr[1:0] != 2'h1)));
			chk(32'({a_lvl, b_lvl, a_sw, b_sw}), 32'({lv[6], lv[4], lv[3:0]}));
			chk(32'({a_tr, b_tr}), 32'({pct(tr[5:4]), pct(tr[1:0])}));
		end
		end_sim();
	end
endmodule
